//--- design/lpx_pkg.sv
package lpx_pkg;

    // link geometry
    localparam int LPX_BITS = 28;
    localparam int LPX_LANES = 4;
    localparam int LPX_SLOTS = 7;
    localparam int LPX_PER_W = 8;

    // parallel input bit index that feeds each slot of each lane
    typedef logic [4:0] lpx_idx_t;
    localparam lpx_idx_t LPX_MAP [LPX_LANES][LPX_SLOTS] = '{
        '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07},
        '{5'h08, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12},
        '{5'h13, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A},
        '{5'h1B, 5'h05, 5'h0A, 5'h0B, 5'h10, 5'h11, 5'h17}
    };

    // control bits carried on the third lane
    localparam int LPX_HSYNC_BIT = 24;
    localparam int LPX_VSYNC_BIT = 25;
    localparam int LPX_DE_BIT = 26;

    // clock lane pattern, slot 0 sent first
    localparam logic [LPX_SLOTS-1:0] LPX_CLK_PATTERN = 7'h63;
    localparam logic [3:0] LPX_SLOT_STEP = 4'h7;

    // timing
    localparam int LPX_CLK_NS = 10;
    localparam int LPX_EN_TIME_NS = 6000;
    localparam int LPX_EN_TIME_CYC = LPX_EN_TIME_NS / LPX_CLK_NS;
    localparam int LPX_EN_W = 10;
    localparam int LPX_LOCK_EDGES = 3;
    localparam int LPX_STALL_CYC = 64;

    // register byte addresses
    localparam logic [7:0] LPX_CTRL_ADDR = 8'h00;
    localparam logic [7:0] LPX_STATUS_ADDR = 8'h04;
    localparam logic [7:0] LPX_CAPTURE_ADDR = 8'h08;
    localparam logic [7:0] LPX_PERIOD_ADDR = 8'h0C;

    // control register fields
    localparam int LPX_CTRL_LANE3_EN = 0;
    localparam int LPX_CTRL_SW_DOWN = 1;
    localparam int LPX_CTRL_W = 2;
    localparam logic [LPX_CTRL_W-1:0] LPX_CTRL_RST = 2'h1;

    // status register fields
    localparam int LPX_ST_LOCKED = 0;
    localparam int LPX_ST_POWERED = 1;
    localparam int LPX_ST_LOCK_LATE = 2;
    localparam int LPX_ST_EDGE_SEL = 3;

    localparam logic [1:0] LPX_HTRANS_NONSEQ = 2'h2;
    localparam logic LPX_HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } lpx_ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } lpx_ahb_rsp_s;

    typedef struct packed {
        logic [LPX_LANES-1:0] serial_lane;
        logic [LPX_LANES-1:0] serial_lane_oe;
        logic link_clock_lane;
        logic link_clock_oe;
    } lpx_link_s;

endpackage : lpx_pkg

//--- design/lpx_lane_shift.sv
`timescale 1ns/1ns
module lpx_lane_shift #(
    parameter int W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic clear,
    input wire logic load,
    input wire logic advance,
    input wire logic [W-1:0] word,
    // serial bit
    output logic bit_out
);
    typedef struct packed {
        logic [W-1:0] sh;
    } lpx_shift_s;

    lpx_shift_s q, d;

    always_comb begin
        d = q;
        if (clear) begin
            d.sh = '0;
        end else if (load) begin
            d.sh = word;
        end else if (advance) begin
            d.sh = q.sh >> 1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bit_out = q.sh[0];

endmodule : lpx_lane_shift

//--- design/lpx_top.sv
// Behaviour
// RQ1: capture all 28 input bits on active edge
// RQ2: select input high means rising capture edge
// RQ3: select input low means falling capture edge
// RQ4: power-down stops serializer and disables lane drivers
// RQ5: power-down clears every datapath register to zero; the input synchroniser stages keep sampling
// RQ6: power-down high means normal capture and transmit
// RQ7: source numbers colour bits from zero upward
// RQ8: syncs and enable on bits 24-26, lane two
// RQ9: msb format puts top colour bits on lane three
// RQ10: lsb format puts low colour bits on lane three
// RQ11: 18-bit hosts hold lane three inputs low
// RQ12: 12-bit hosts fill low inputs by copy or constants
// RQ13: source drives spare and unused inputs valid
// RQ14: host sends black data over 1 ms after release
// RQ15: host sends black, powers down, waits 250 ns
// RQ16: each lane sends seven slots per pixel period
// RQ17: lock and valid lanes within enable time
// RQ18: 28 bits split into four 7-bit lane words
// RQ19: clock lane repeats fixed pattern each period
// RQ20: fixed slot order per lane from bit map
`timescale 1ns/1ns
module lpx_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pixel source pins
    input wire logic pixel_clock_in,
    input wire logic [lpx_pkg::LPX_BITS-1:0] parallel_in_bits,
    input wire logic capture_edge_select,
    input wire logic power_down_n,
    // register bus
    input wire lpx_pkg::lpx_ahb_req_s ahb_req,
    output lpx_pkg::lpx_ahb_rsp_s ahb_rsp,
    // serial link pins
    output lpx_pkg::lpx_link_s link
);
    import lpx_pkg::*;

    typedef struct packed {
        logic [2:0] pclk_sync;
        logic [2:0] sel_sync;
        logic [2:0] pdn_sync;
        logic [LPX_BITS-1:0] din_s1;
        logic [LPX_BITS-1:0] din_s2;
        logic [LPX_BITS-1:0] din_s3;
        logic [LPX_BITS-1:0] din_lvl;
        logic pclk_lvl;
        logic sel_lvl;
        logic pdn_lvl;
        logic [LPX_PER_W-1:0] per_cnt;
        logic [LPX_PER_W-1:0] period;
        logic [LPX_PER_W:0] acc;
        logic [2:0] slot;
        logic [1:0] edges;
        logic locked;
        logic [LPX_EN_W-1:0] en_cnt;
        logic lock_late;
        // set once lock is reached after power-up
        logic lock_seen;
        logic [LPX_BITS-1:0] capture;
        logic [LPX_LANES-1:0] lane_oe;
        logic clk_oe;
        logic [LPX_CTRL_W-1:0] ctrl;
        logic pend;
        logic pwr;
        logic [7:0] paddr;
        logic hready;
        logic [31:0] hrdata;
    } lpx_state_s;

    localparam logic [LPX_PER_W-1:0] STALL =
        LPX_PER_W'(LPX_STALL_CYC);
    localparam logic [LPX_EN_W-1:0] EN_LAST =
        LPX_EN_W'(LPX_EN_TIME_CYC - 1);
    localparam logic [1:0] LOCK_LAST = 2'(LPX_LOCK_EDGES - 1);
    localparam logic [2:0] SLOT_LAST = 3'(LPX_SLOTS - 1);

    lpx_state_s q, d;

    logic [LPX_LANES-1:0][LPX_SLOTS-1:0] words;
    logic [LPX_LANES-1:0] lane_bit;
    logic clk_bit;
    logic powered;
    logic cap_edge;
    logic load;
    logic advance;
    logic [LPX_PER_W:0] acc_sum;
    logic [LPX_PER_W:0] span;
    logic [31:0] rd_data;

    assign powered = q.pdn_lvl & ~q.ctrl[LPX_CTRL_SW_DOWN]; // [RQ6]

    // lane words straight from the synchronised input bits
    for (genvar l = 0; l < LPX_LANES; l++) begin : g_map
        for (genvar k = 0; k < LPX_SLOTS; k++) begin : g_slot
            // [RQ18] [RQ20] [RQ8]
            assign words[l][k] = q.din_lvl[LPX_MAP[l][k]];
        end
    end

    // read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (q.paddr)
            LPX_CTRL_ADDR: rd_data = 32'(q.ctrl);
            LPX_STATUS_ADDR: begin
                rd_data[LPX_ST_LOCKED] = q.locked;
                rd_data[LPX_ST_POWERED] = powered;
                rd_data[LPX_ST_LOCK_LATE] = q.lock_late;
                rd_data[LPX_ST_EDGE_SEL] = q.sel_lvl;
            end
            LPX_CAPTURE_ADDR: rd_data = 32'(q.capture);
            LPX_PERIOD_ADDR: rd_data = 32'(q.period);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        d = q;
        cap_edge = 1'b0;
        load = 1'b0;
        advance = 1'b0;
        acc_sum = q.acc + (LPX_PER_W + 1)'(LPX_SLOT_STEP);
        span = (LPX_PER_W + 1)'(q.period) - 1'b1;

        // three-stage synchronisers on every pixel source pin
        d.pclk_sync = {q.pclk_sync[1:0], pixel_clock_in};
        d.sel_sync = {q.sel_sync[1:0], capture_edge_select};
        d.pdn_sync = {q.pdn_sync[1:0], power_down_n};
        d.din_s1 = parallel_in_bits;
        d.din_s2 = q.din_s1;
        d.din_s3 = q.din_s2;

        if (q.sel_sync[1] == q.sel_sync[2]) begin
            d.sel_lvl = q.sel_sync[2];
        end
        if (q.pdn_sync[1] == q.pdn_sync[2]) begin
            d.pdn_lvl = q.pdn_sync[2];
        end
        // a data bit changes once stages two and three agree
        for (int i = 0; i < LPX_BITS; i++) begin
            if (q.din_s2[i] == q.din_s3[i]) begin
                d.din_lvl[i] = q.din_s3[i];
            end
        end

        // pixel clock edge detection
        if (q.pclk_sync[1] == q.pclk_sync[2] &&
            q.pclk_sync[2] != q.pclk_lvl) begin
            d.pclk_lvl = q.pclk_sync[2];
            // [RQ2] [RQ3]
            cap_edge = powered && (q.pclk_sync[2] == q.sel_lvl);
        end

        if (!powered) begin
            // [RQ4] [RQ5]
            d.per_cnt = '0;
            d.period = '0;
            d.acc = '0;
            d.slot = '0;
            d.edges = '0;
            d.locked = 1'b0;
            d.en_cnt = '0;
            d.lock_late = 1'b0;
            d.lock_seen = 1'b0;
            d.capture = '0;
            d.lane_oe = '0;
            d.clk_oe = 1'b0;
        end else begin
            if (q.per_cnt != STALL) begin
                d.per_cnt = q.per_cnt + 1'b1;
            end else begin
                // pixel clock stopped: drop lock
                d.locked = 1'b0;
                d.edges = '0;
            end

            // [RQ17] flag when lock misses the enable time
            if (q.en_cnt != EN_LAST) begin
                d.en_cnt = q.en_cnt + 1'b1;
            end else if (!q.locked && !q.lock_seen) begin
                // a later stall of the pixel clock is not a late lock
                d.lock_late = 1'b1;
            end

            // seven slots spread over one measured period; dividing by one
            // clk less lets the last slot survive a period one clk shorter
            // than the one measured, as the sampled pixel clock jitters
            if (q.slot != SLOT_LAST && q.period != '0) begin
                if (acc_sum >= span) begin
                    d.acc = acc_sum - span;
                    d.slot = q.slot + 1'b1;
                    advance = 1'b1; // [RQ16]
                end else begin
                    d.acc = acc_sum;
                end
            end

            if (cap_edge) begin
                d.capture = q.din_lvl; // [RQ1]
                d.period = q.per_cnt + 1'b1;
                d.per_cnt = '0;
                d.acc = '0;
                d.slot = '0;
                load = 1'b1; // [RQ18] [RQ19]
                if (q.edges != LOCK_LAST) begin
                    d.edges = q.edges + 1'b1;
                end else begin
                    d.locked = 1'b1; // [RQ17]
                end
            end

            // drivers on only while locked
            if (d.locked) begin
                d.lane_oe = {q.ctrl[LPX_CTRL_LANE3_EN], 3'h7}; // [RQ6]
                d.clk_oe = 1'b1;
                d.lock_seen = 1'b1;
            end else begin
                d.lane_oe = '0; // [RQ4]
                d.clk_oe = 1'b0;
            end
        end

        // bus slave: one wait state per transfer
        if (q.pend) begin
            d.pend = 1'b0;
            d.hready = 1'b1;
            if (q.pwr) begin
                if (q.paddr == LPX_CTRL_ADDR) begin
                    d.ctrl = ahb_req.hwdata[LPX_CTRL_W-1:0];
                end
            end else begin
                d.hrdata = rd_data;
            end
        end else if (ahb_req.hsel && ahb_req.hready &&
                     ahb_req.htrans == LPX_HTRANS_NONSEQ) begin
            d.pend = 1'b1;
            d.hready = 1'b0;
            d.pwr = ahb_req.hwrite;
            d.paddr = ahb_req.haddr[7:0];
            if (ahb_req.haddr[31:8] != '0) begin
                d.paddr = 8'hFF;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.ctrl <= LPX_CTRL_RST;
            q.hready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // data lanes
    for (genvar l = 0; l < LPX_LANES; l++) begin : g_lane
        lpx_lane_shift #(
            .W(LPX_SLOTS)
        ) u_shift (
            .clk(clk),
            .nrst(nrst),
            .clear(~powered), // [RQ5]
            .load(load),
            .advance(advance), // [RQ16]
            .word(words[l]),
            .bit_out(lane_bit[l])
        );
    end

    // clock lane
    lpx_lane_shift #(
        .W(LPX_SLOTS)
    ) u_clk_shift (
        .clk(clk),
        .nrst(nrst),
        .clear(~powered),
        .load(load),
        .advance(advance),
        .word(LPX_CLK_PATTERN), // [RQ19]
        .bit_out(clk_bit)
    );

    assign link.serial_lane = lane_bit;
    assign link.serial_lane_oe = q.lane_oe;
    assign link.link_clock_lane = clk_bit;
    assign link.link_clock_oe = q.clk_oe;

    assign ahb_rsp.hrdata = q.hrdata;
    assign ahb_rsp.hreadyout = q.hready;
    assign ahb_rsp.hresp = LPX_HRESP_OKAY;

endmodule : lpx_top

//--- test/lpx_checker.sv
`timescale 1ns/1ns
module lpx_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pixel source pins
    input wire logic pixel_clock_in,
    input wire logic [lpx_pkg::LPX_BITS-1:0] parallel_in_bits,
    input wire logic capture_edge_select,
    input wire logic power_down_n,
    // bus and link
    input wire lpx_pkg::lpx_ahb_req_s ahb_req,
    input wire lpx_pkg::lpx_ahb_rsp_s ahb_rsp,
    input wire lpx_pkg::lpx_link_s link
);
    import lpx_pkg::*;
    logic [7:0] still_q;
    logic [7:0] still_d;
    logic pclk_q;
    // cycles since the pixel clock last changed, saturating
    always_comb begin
        still_d = still_q + {7'h00, still_q != 8'hFF};
        if (pixel_clock_in != pclk_q) begin
            still_d = 8'h00;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            still_q <= 8'h00;
            pclk_q <= 1'b0;
        end else begin
            still_q <= still_d;
            pclk_q <= pixel_clock_in;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_okay; ahb_rsp.hresp == LPX_HRESP_OKAY; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_take;
        ahb_req.hsel && ahb_req.hready && ahb_req.htrans == LPX_HTRANS_NONSEQ
        |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
    endproperty
    a_take: assert property (p_take) else $error("wait state wrong");
    property p_wait1; !ahb_rsp.hreadyout |=> ahb_rsp.hreadyout; endproperty
    a_wait1: assert property (p_wait1) else $error("wait state too long");
    property p_pd_off;
        !power_down_n [*6] |-> link.serial_lane_oe == 4'h0 && !link.link_clock_oe;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("driver on in power down");
    property p_pd_clr;
        !power_down_n [*6] |-> link.serial_lane == 4'h0 && !link.link_clock_lane;
    endproperty
    a_pd_clr: assert property (p_pd_clr) else $error("lane not cleared");
    property p_oe_pair; link.serial_lane_oe[2:0] == {3{link.link_clock_oe}}; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("enables apart");
    property p_lane3; link.serial_lane_oe[3] |-> link.link_clock_oe; endproperty
    a_lane3: assert property (p_lane3) else $error("lane 3 alone on");
    property p_lock; $rose(power_down_n) |-> ##[1:610] link.link_clock_oe; endproperty
    a_lock: assert property (p_lock) else $error("no lock in time");
    property p_stall; still_q == 8'h5A |-> !link.link_clock_oe; endproperty
    a_stall: assert property (p_stall) else $error("enabled without clock");
    c_lock: cover property ($rose(link.link_clock_oe));
    c_down: cover property (!power_down_n [*6]);
    c_stall: cover property (still_q == 8'h5A);
endmodule : lpx_checker

bind lpx_top lpx_checker u_chk (
    .clk(clk),
    .nrst(nrst),
    .pixel_clock_in(pixel_clock_in),
    .parallel_in_bits(parallel_in_bits),
    .capture_edge_select(capture_edge_select),
    .power_down_n(power_down_n),
    .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp),
    .link(link)
);

//--- test/lpx_src.sv
`timescale 1ns/1ns
module lpx_src (
    // control
    input wire logic run,
    input wire logic [27:0] word_a,
    input wire logic [27:0] word_b,
    // pixel pins
    output logic pclk,
    output logic [27:0] pdata
);
    // word_a shows after the rising edge, word_b after the falling one
    initial begin
        pclk = 1'b0;
        pdata = 28'h0000000;
        forever begin
            wait (run);
            #22 pclk = 1'b1;
            #40 pdata = word_a;
            #23 pclk = 1'b0;
            #40 pdata = word_b;
        end
    end
endmodule : lpx_src

//--- test/lvds_pixel_serializer_tb.sv
`timescale 1ns/1ns
module lvds_pixel_serializer_tb;
    import lpx_pkg::*;
    localparam int MAP [28] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 12, 13, 14, 15, 18,
        19, 20, 21, 22, 24, 25, 26, 27, 5, 10, 11, 16, 17, 23};
    localparam logic [6:0] CK = 7'h63;
    logic clk = 1'b0;
    logic nrst, power_down_n, sel, run, pclk;
    logic [27:0] src_a, src_b, pdata, w, a, b;
    logic [31:0] s, v;
    lpx_ahb_req_s q, req_w;
    lpx_ahb_rsp_s ahb_rsp;
    lpx_link_s link;
    int errors = 0;
    int n_tests = 0;
    assign req_w = {q[$bits(q)-1:1], ahb_rsp.hreadyout};
    always #5 clk = ~clk;
    lpx_src u_src (.run(run), .word_a(src_a), .word_b(src_b), .pclk(pclk),
        .pdata(pdata));
    lpx_top u_dut (.clk(clk), .nrst(nrst), .pixel_clock_in(pclk),
        .parallel_in_bits(pdata), .capture_edge_select(sel),
        .power_down_n(power_down_n), .ahb_req(req_w), .ahb_rsp(ahb_rsp),
        .link(link));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // lane 0 toggles every slot, lane 1 marks the slot 6 to 0 boundary
    function automatic logic [27:0] mk(input logic [27:0] x);
        return (x & ~28'h00401DF) | 28'h0040095;
    endfunction : mk
    task automatic print_verdict();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ahb_rsp.hreadyout !== 1'b1 && n < 20);
        if (ahb_rsp.hreadyout !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] ad,
        input logic [31:0] wd);
        @(posedge clk);
        q.hsel <= 1'b1;
        q.haddr <= {24'h000000, ad};
        q.htrans <= LPX_HTRANS_NONSEQ;
        q.hwrite <= wr;
        q.hsize <= 3'h2;
        wait_rdy();
        q.htrans <= 2'h0;
        q.hwdata <= wd;
        wait_rdy();
        v = ahb_rsp.hrdata;
    endtask : bus
    task automatic wait_lock();
        for (int n = 0; n < 250; n++) begin
            bus(1'b0, LPX_STATUS_ADDR, 32'h0);
            if (v[0] === 1'b1)
                break;
        end
        check(v[0], 1'b1);
    endtask : wait_lock
    task automatic chk_lanes(input logic [27:0] x);
        logic [4:0] p, c;
        logic [4:0] g [7];
        int slot, cnt;
        src_a <= x;
        src_b <= x;
        repeat (60) @(posedge clk);
        p = {link.serial_lane, link.link_clock_lane};
        slot = -1;
        cnt = 0;
        for (int n = 0; n < 60; n++) begin
            @(posedge clk);
            c = {link.serial_lane, link.link_clock_lane};
            if (slot >= 0 && c[2:1] != p[2:1]) begin
                slot = (slot + 1) % 7;
                cnt++;
            end
            if (c[0] && !p[0]) begin
                if (cnt > 0)
                    break;
                slot = 5;
            end
            if (slot >= 0)
                g[slot] = c;
            p = c;
        end
        check(cnt, 7);
        for (int k = 0; k < 7; k++) begin
            check(g[k][0], CK[k]);
            for (int l = 0; l < 4; l++)
                check(g[k][l+1], x[MAP[l*7+k]]);
        end
    endtask : chk_lanes
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        print_verdict();
    end
    initial begin
        nrst = 1'b0;
        power_down_n = 1'b0;
        sel = 1'b1;
        run = 1'b1;
        q = '0;
        src_a = '0;
        src_b = '0;
        s = 32'h0000003D;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, LPX_CTRL_ADDR, 32'h0);
        check(v, 32'h00000001);
        bus(1'b1, LPX_STATUS_ADDR, 32'hFFFFFFFF);
        bus(1'b0, LPX_STATUS_ADDR, 32'h0);
        check(v, 32'h00000008);
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        check(v, 32'h00000000);
        power_down_n <= 1'b1;
        wait_lock();
        bus(1'b0, LPX_PERIOD_ADDR, 32'h0);
        check(v === 32'h0000000C || v === 32'h0000000D, 1'b1);
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            w = mk(s[27:0]);
            if (i == 0)
                w = w & ~28'h8830C20;
            if (i == 1)
                w[26:24] = 3'h5;
            if (i == 2) begin
                // 12-bit host, inputs 14:13 and 22:21 copy inputs 8:7 and 18, 15
                w = w & ~28'h8830C20;
                w[14:13] = w[8:7];
                w[22:21] = {w[18], w[15]};
            end
            chk_lanes(w);
        end
        s = lfsr(s);
        a = s[27:0];
        s = lfsr(s);
        b = s[27:0];
        src_a <= a;
        src_b <= b;
        repeat (60) @(posedge clk);
        bus(1'b0, LPX_CAPTURE_ADDR, 32'h0);
        check(v, {4'h0, b});
        sel <= 1'b0;
        repeat (60) @(posedge clk);
        bus(1'b0, LPX_CAPTURE_ADDR, 32'h0);
        check(v, {4'h0, a});
        bus(1'b1, LPX_CTRL_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        check(link.serial_lane_oe, 4'h7);
        bus(1'b1, LPX_CTRL_ADDR, 32'h3);
        repeat (3) @(posedge clk);
        check(link.serial_lane_oe, 4'h0);
        bus(1'b1, LPX_CTRL_ADDR, 32'h1);
        wait_lock();
        run <= 1'b0;
        repeat (700) @(posedge clk);
        bus(1'b0, LPX_STATUS_ADDR, 32'h0);
        check(v[0], 1'b0);
        check(v[2], 1'b0);
        run <= 1'b1;
        wait_lock();
        src_a <= '0;
        src_b <= '0;
        repeat (30) @(posedge clk);
        power_down_n <= 1'b0;
        repeat (8) @(posedge clk);
        check(link, 32'h0);
        bus(1'b0, LPX_CAPTURE_ADDR, 32'h0);
        check(v, 32'h0);
        bus(1'b0, LPX_PERIOD_ADDR, 32'h0);
        check(v, 32'h0);
        power_down_n <= 1'b1;
        wait_lock();
        print_verdict();
    end
endmodule : lvds_pixel_serializer_tb
